// [bfw_pkg.sv]
package bfw_pkg;

    // register indices; byte address on APB is four times the index
    localparam int unsigned    IDX_W           = 10;
    localparam logic [IDX_W-1:0] IO_BASE_IDX   = 10'h01c;
    localparam logic [IDX_W-1:0] IO_LIMIT_IDX  = 10'h01d;
    localparam logic [IDX_W-1:0] NP_BASE_IDX   = 10'h020;
    localparam logic [IDX_W-1:0] NP_LIMIT_IDX  = 10'h022;
    localparam logic [IDX_W-1:0] PM_BASE_IDX   = 10'h024;
    localparam logic [IDX_W-1:0] PM_LIMIT_IDX  = 10'h026;
    localparam logic [IDX_W-1:0] PM_BASEU_IDX  = 10'h028;
    localparam logic [IDX_W-1:0] PM_LIMITU_IDX = 10'h02c;
    localparam logic [IDX_W-1:0] IO_BASEU_IDX  = 10'h030;
    localparam logic [IDX_W-1:0] IO_LIMITU_IDX = 10'h032;

    // field positions
    localparam int unsigned    CAP_BIT         = 0;
    localparam int unsigned    FIELD_LSB       = 4;
    localparam int unsigned    MEM_FIELD_MSB   = 15;
    localparam int unsigned    IO_FIELD_MSB    = 7;

    // reset values
    localparam logic           IO_CAP_RST      = 1'b1;
    localparam logic [3:0]     IO_BASE_RST     = 4'hf;
    localparam logic [3:0]     IO_LIMIT_RST    = 4'h0;
    localparam logic [11:0]    NP_BASE_RST     = 12'h000;
    localparam logic [11:0]    NP_LIMIT_RST    = 12'h000;
    localparam logic           PM_CAP_RST      = 1'b1;
    localparam logic [11:0]    PM_BASE_RST     = 12'hfff;
    localparam logic [11:0]    PM_LIMIT_RST    = 12'h000;
    localparam logic [31:0]    PM_BASEU_RST    = 32'hffffffff;
    localparam logic [31:0]    PM_LIMITU_RST   = 32'h00000000;
    localparam logic [15:0]    IO_BASEU_RST    = 16'hffff;
    localparam logic [15:0]    IO_LIMITU_RST   = 16'h0000;

    // implied low address bits of a window
    localparam logic [19:0]    MEM_LOW_ONES    = 20'hfffff;
    localparam logic [19:0]    MEM_LOW_ZEROS   = 20'h00000;
    localparam logic [11:0]    IO_LOW_ONES     = 12'hfff;
    localparam logic [11:0]    IO_LOW_ZEROS    = 12'h000;

endpackage

// [bfw_cfg_if.sv]
`timescale 1ns/10ps
interface bfw_cfg_if;
    logic                       wr_en;
    logic [bfw_pkg::IDX_W-1:0]  idx;
    logic [31:0]                wdata;
    logic [3:0]                 strb;
    logic [31:0]                rdata;
    logic                       mapped;

    modport front (
        output wr_en,
        output idx,
        output wdata,
        output strb,
        input  rdata,
        input  mapped
    );
    modport core (
        input  wr_en,
        input  idx,
        input  wdata,
        input  strb,
        output rdata,
        output mapped
    );
endinterface // bfw_cfg_if

// [bfw_apb_slave.sv]
`timescale 1ns/10ps
module bfw_apb_slave #(
    parameter int unsigned AW = 12
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [AW-1:0] paddr_i,
    input  wire logic [31:0]   pwdata_i,
    input  wire logic [3:0]    pstrb_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    bfw_cfg_if.front           cfg
);
    import bfw_pkg::*;

    logic        setup;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;

    assign setup     = psel_i & ~penable_i;
    assign cfg.idx   = paddr_i[AW-1:2];
    assign cfg.wdata = pwdata_i;
    assign cfg.strb  = pstrb_i;
    // the write lands on the very edge where the master sees pready high
    assign cfg.wr_en = psel_i & penable_i & pwrite_i & pready_q;

    // no wait states: answer is always in the first access cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= ~cfg.mapped;
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    // read data captured in setup so the access phase sees it from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata_q <= 32'h00000000;
        end else if (setup) begin
            prdata_q <= (!pwrite_i && cfg.mapped) ? cfg.rdata : 32'h00000000;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;

endmodule // bfw_apb_slave

// [bfw_window.sv]
`timescale 1ns/10ps
module bfw_window #(
    parameter int unsigned AW = 32
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [AW-1:0] base_i,
    input  wire logic [AW-1:0] limit_i,
    input  wire logic [AW-1:0] addr_i,
    output logic               hit_o
);
    logic hit_q;

    // inclusive on both ends; base above limit gives an empty window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hit_q <= 1'b0;
        end else begin
            hit_q <= (addr_i >= base_i) && (addr_i <= limit_i);
        end
    end

    assign hit_o = hit_q;

endmodule // bfw_window

// [bfw_bridge_window_regs.sv]
// Operation
// - non-prefetch limit field, low twenty bits ones
// - non-prefetch base/limit decide memory forwarding
// - non-prefetch base field, 1MB aligned
// - prefetch 64-bit capability bit, resets one
// - prefetch limit bit0 mirrors capability, read-only
// - prefetch base field resets to 0xfff
// - prefetch limit field resets zero, low ones
// - prefetch window uses base, limit, uppers
// - base upper zero, write-ignored without capability
// - limit upper resets zero, capability gated
// - I/O base upper resets 0xffff, gated
// - I/O limit upper resets zero, gated
// - I/O capability selects 16 or 32 bit
`timescale 1ns/10ps
module bfw_bridge_window_regs #(
    parameter int unsigned AW = 12
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [AW-1:0] paddr_i,
    input  wire logic [31:0]   pwdata_i,
    input  wire logic [3:0]    pstrb_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic [31:0]   np_addr_i,
    input  wire logic [63:0]   pref_addr_i,
    input  wire logic [31:0]   io_addr_i,
    output logic               np_hit_o,
    output logic               pref_hit_o,
    output logic               io_hit_o,
    output logic               pref_addr64_capable_o,
    output logic               io_addr32_capable_o
);
    import bfw_pkg::*;

    bfw_cfg_if cfg ();

    logic        io_addr32_capable_q;
    logic [3:0]  io_window_base_q;
    logic [3:0]  io_window_limit_q;
    logic [11:0] nonpref_mem_base_q;
    logic [11:0] nonpref_mem_limit_q;
    logic        pref_addr64_capable_q;
    logic [11:0] pref_mem_base_q;
    logic [11:0] pref_mem_limit_q;
    logic [31:0] pref_mem_base_upper_q;
    logic [31:0] pref_mem_limit_upper_q;
    logic [15:0] io_base_upper_q;
    logic [15:0] io_limit_upper_q;

    logic        wr_lane0;
    logic        wr_lane1;
    logic [31:0] rdata_d;
    logic        mapped_d;

    bfw_apb_slave #(
        .AW        (AW)
    ) u_apb (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .pstrb_i   (pstrb_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .cfg       (cfg.front)
    );

    assign wr_lane0 = cfg.wr_en & cfg.strb[0];
    assign wr_lane1 = cfg.wr_en & cfg.strb[1];

    // I/O base: capability bit and 4KB-aligned base nibble
    // io capability
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_addr32_capable_q <= IO_CAP_RST;
            io_window_base_q    <= IO_BASE_RST;
        end else if (wr_lane0 && cfg.idx == IO_BASE_IDX) begin
            io_addr32_capable_q <= cfg.wdata[CAP_BIT];
            io_window_base_q    <= cfg.wdata[IO_FIELD_MSB:FIELD_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_window_limit_q <= IO_LIMIT_RST;
        end else if (wr_lane0 && cfg.idx == IO_LIMIT_IDX) begin
            io_window_limit_q <= cfg.wdata[IO_FIELD_MSB:FIELD_LSB];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nonpref_mem_base_q <= NP_BASE_RST;
        end else if (cfg.idx == NP_BASE_IDX) begin
            if (wr_lane0) begin
                nonpref_mem_base_q[3:0] <= cfg.wdata[7:FIELD_LSB];
            end
            if (wr_lane1) begin
                nonpref_mem_base_q[11:4] <= cfg.wdata[MEM_FIELD_MSB:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nonpref_mem_limit_q <= NP_LIMIT_RST;
        end else if (cfg.idx == NP_LIMIT_IDX) begin
            if (wr_lane0) begin
                nonpref_mem_limit_q[3:0] <= cfg.wdata[7:FIELD_LSB];
            end
            if (wr_lane1) begin
                nonpref_mem_limit_q[11:4] <= cfg.wdata[MEM_FIELD_MSB:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pref_addr64_capable_q <= PM_CAP_RST;
        end else if (wr_lane0 && cfg.idx == PM_BASE_IDX) begin
            pref_addr64_capable_q <= cfg.wdata[CAP_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pref_mem_base_q <= PM_BASE_RST;
        end else if (cfg.idx == PM_BASE_IDX) begin
            if (wr_lane0) begin
                pref_mem_base_q[3:0] <= cfg.wdata[7:FIELD_LSB];
            end
            if (wr_lane1) begin
                pref_mem_base_q[11:4] <= cfg.wdata[MEM_FIELD_MSB:8];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pref_mem_limit_q <= PM_LIMIT_RST;
        end else if (cfg.idx == PM_LIMIT_IDX) begin
            if (wr_lane0) begin
                pref_mem_limit_q[3:0] <= cfg.wdata[7:FIELD_LSB];
            end
            if (wr_lane1) begin
                pref_mem_limit_q[11:4] <= cfg.wdata[MEM_FIELD_MSB:8];
            end
        end
    end

    // upper registers: writes dropped while the wider mode is off, so
    // re-enabling the capability brings back the last value written with it on
    for (genvar lane = 0; lane < 4; lane++) begin : g_pm_upper
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pref_mem_base_upper_q[lane*8 +: 8] <= PM_BASEU_RST[lane*8 +: 8];
            end else if (cfg.wr_en && cfg.strb[lane] && pref_addr64_capable_q &&
                         cfg.idx == PM_BASEU_IDX) begin
                pref_mem_base_upper_q[lane*8 +: 8] <= cfg.wdata[lane*8 +: 8];
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pref_mem_limit_upper_q[lane*8 +: 8] <= PM_LIMITU_RST[lane*8 +: 8];
            end else if (cfg.wr_en && cfg.strb[lane] && pref_addr64_capable_q &&
                         cfg.idx == PM_LIMITU_IDX) begin
                pref_mem_limit_upper_q[lane*8 +: 8] <= cfg.wdata[lane*8 +: 8];
            end
        end
    end

    for (genvar lane = 0; lane < 2; lane++) begin : g_io_upper
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                io_base_upper_q[lane*8 +: 8] <= IO_BASEU_RST[lane*8 +: 8];
            end else if (cfg.wr_en && cfg.strb[lane] && io_addr32_capable_q &&
                         cfg.idx == IO_BASEU_IDX) begin
                io_base_upper_q[lane*8 +: 8] <= cfg.wdata[lane*8 +: 8];
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                io_limit_upper_q[lane*8 +: 8] <= IO_LIMITU_RST[lane*8 +: 8];
            end else if (cfg.wr_en && cfg.strb[lane] && io_addr32_capable_q &&
                         cfg.idx == IO_LIMITU_IDX) begin
                io_limit_upper_q[lane*8 +: 8] <= cfg.wdata[lane*8 +: 8];
            end
        end
    end

    // read mux; reserved bits and unmapped words read zero
    always_comb begin
        rdata_d  = 32'h00000000;
        mapped_d = 1'b1;
        case (cfg.idx)
            IO_BASE_IDX: begin
                rdata_d[CAP_BIT]                  = io_addr32_capable_q;
                rdata_d[IO_FIELD_MSB:FIELD_LSB]   = io_window_base_q;
            end
            IO_LIMIT_IDX: begin
                rdata_d[CAP_BIT]                  = io_addr32_capable_q;
                rdata_d[IO_FIELD_MSB:FIELD_LSB]   = io_window_limit_q;
            end
            NP_BASE_IDX: begin
                rdata_d[MEM_FIELD_MSB:FIELD_LSB]  = nonpref_mem_base_q;
            end
            NP_LIMIT_IDX: begin
                rdata_d[MEM_FIELD_MSB:FIELD_LSB]  = nonpref_mem_limit_q;
            end
            PM_BASE_IDX: begin
                rdata_d[CAP_BIT]                  = pref_addr64_capable_q;
                rdata_d[MEM_FIELD_MSB:FIELD_LSB]  = pref_mem_base_q;
            end
            PM_LIMIT_IDX: begin
                rdata_d[CAP_BIT]                  = pref_addr64_capable_q;
                rdata_d[MEM_FIELD_MSB:FIELD_LSB]  = pref_mem_limit_q;
            end
            PM_BASEU_IDX: begin
                rdata_d = pref_addr64_capable_q ? pref_mem_base_upper_q : 32'h00000000;
            end
            PM_LIMITU_IDX: begin
                rdata_d = pref_addr64_capable_q ? pref_mem_limit_upper_q : 32'h00000000;
            end
            IO_BASEU_IDX: begin
                rdata_d[15:0] = io_addr32_capable_q ? io_base_upper_q : 16'h0000;
            end
            IO_LIMITU_IDX: begin
                rdata_d[15:0] = io_addr32_capable_q ? io_limit_upper_q : 16'h0000;
            end
            default: begin
                mapped_d = 1'b0;
            end
        endcase
    end

    assign cfg.rdata  = rdata_d;
    assign cfg.mapped = mapped_d;

    // assembled windows; upper halves forced to zero in the narrow modes
    logic [31:0] np_base;
    logic [31:0] np_limit;
    logic [63:0] pm_base;
    logic [63:0] pm_limit;
    logic [31:0] io_base;
    logic [31:0] io_limit;
    logic [31:0] pm_base_hi;
    logic [31:0] pm_limit_hi;
    logic [15:0] io_base_hi;
    logic [15:0] io_limit_hi;

    assign np_base     = {nonpref_mem_base_q, MEM_LOW_ZEROS};
    assign np_limit    = {nonpref_mem_limit_q, MEM_LOW_ONES};
    assign pm_base_hi  = pref_addr64_capable_q ? pref_mem_base_upper_q : 32'h00000000;
    assign pm_limit_hi = pref_addr64_capable_q ? pref_mem_limit_upper_q : 32'h00000000;
    assign pm_base     = {pm_base_hi, pref_mem_base_q, MEM_LOW_ZEROS};
    assign pm_limit    = {pm_limit_hi, pref_mem_limit_q, MEM_LOW_ONES};
    assign io_base_hi  = io_addr32_capable_q ? io_base_upper_q : 16'h0000;
    assign io_limit_hi = io_addr32_capable_q ? io_limit_upper_q : 16'h0000;
    assign io_base     = {io_base_hi, io_window_base_q, IO_LOW_ZEROS};
    assign io_limit    = {io_limit_hi, io_window_limit_q, IO_LOW_ONES};

    bfw_window #(
        .AW      (32)
    ) u_np_win (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .base_i  (np_base),
        .limit_i (np_limit),
        .addr_i  (np_addr_i),
        .hit_o   (np_hit_o)
    );

    bfw_window #(
        .AW      (64)
    ) u_pm_win (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .base_i  (pm_base),
        .limit_i (pm_limit),
        .addr_i  (pref_addr_i),
        .hit_o   (pref_hit_o)
    );

    bfw_window #(
        .AW      (32)
    ) u_io_win (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .base_i  (io_base),
        .limit_i (io_limit),
        .addr_i  (io_addr_i),
        .hit_o   (io_hit_o)
    );

    assign pref_addr64_capable_o = pref_addr64_capable_q;
    assign io_addr32_capable_o   = io_addr32_capable_q;

endmodule // bfw_bridge_window_regs

// [bfw_regs_chk.sv]
`timescale 1ns/10ps
module bfw_regs_chk #(
    parameter int unsigned AW = 12
) (
    input wire logic          clk_i,
    input wire logic          rst_i,
    input wire logic          psel_i,
    input wire logic          penable_i,
    input wire logic          pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0]   prdata_o,
    input wire logic          pready_o,
    input wire logic          pslverr_o,
    input wire logic          pref_addr64_capable_o,
    input wire logic          io_addr32_capable_o
);
    import bfw_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [IDX_W-1:0] idx;
    logic             rd_ok;
    assign idx   = paddr_i[AW-1:2];
    assign rd_ok = pready_o && !pwrite_i && !pslverr_o;

    a_setup_gets_ready: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_idle_stays_quiet: assert property (!psel_i |=> !pready_o && !pslverr_o)
        else $error("answer without request");
    a_pm_cap_mirror: assert property (rd_ok && idx == PM_LIMIT_IDX |-> prdata_o[0] == pref_addr64_capable_o)
        else $error("limit bit0 differs from capability");
    a_io_cap_mirror: assert property (rd_ok && idx == IO_LIMIT_IDX |-> prdata_o[0] == io_addr32_capable_o)
        else $error("io limit bit0 differs from capability");
    a_pm_upper_zero: assert property (rd_ok && !pref_addr64_capable_o &&
        (idx == PM_BASEU_IDX || idx == PM_LIMITU_IDX) |-> prdata_o == 32'h00000000)
        else $error("prefetch upper not zero without capability");
    a_io_upper_zero: assert property (rd_ok && !io_addr32_capable_o &&
        (idx == IO_BASEU_IDX || idx == IO_LIMITU_IDX) |-> prdata_o == 32'h00000000)
        else $error("io upper not zero without capability");
    a_limit_rsvd_zero: assert property (rd_ok && idx == NP_LIMIT_IDX |-> prdata_o[3:0] == 4'h0 &&
        prdata_o[31:16] == 16'h0000)
        else $error("reserved limit bits set");
    a_caps_after_reset: assert property (disable iff (1'b0) rst_i |=> pref_addr64_capable_o &&
        io_addr32_capable_o)
        else $error("capabilities not one after reset");
endmodule // bfw_regs_chk

bind bfw_bridge_window_regs bfw_regs_chk #(.AW(AW)) chk_u (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .pref_addr64_capable_o, .io_addr32_capable_o);

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
    import bfw_pkg::*;
    logic        clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, np_addr_i = 0, io_addr_i = 0, prdata_o;
    logic [3:0]  pstrb_i = 0;
    logic [63:0] pref_addr_i = 0;
    logic        pready_o, pslverr_o, np_hit_o, pref_hit_o, io_hit_o, pcap, io_addr32_capable;
    int          error_cnt = 0, n_checks = 0, cyc = 0;
    localparam logic [9:0] IDX [10] = '{IO_BASE_IDX, IO_LIMIT_IDX, NP_BASE_IDX, NP_LIMIT_IDX, PM_BASE_IDX,
        PM_LIMIT_IDX, PM_BASEU_IDX, PM_LIMITU_IDX, IO_BASEU_IDX, IO_LIMITU_IDX};
    localparam logic [31:0] WMSK [10] = '{32'hf1, 32'hf0, 32'hfff0, 32'hfff0, 32'hfff1, 32'hfff0,
        32'hffffffff, 32'hffffffff, 32'hffff, 32'hffff};
    localparam logic [31:0] RSTV [10] = '{32'hf1, 32'h0, 32'h0, 32'h0, 32'hfff1, 32'h0, 32'hffffffff,
        32'h0, 32'hffff, 32'h0};
    logic [31:0] mr [10];

    always #50 clk_i = ~clk_i;

    bfw_bridge_window_regs #(.AW(12)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .np_addr_i(np_addr_i), .pref_addr_i(pref_addr_i), .io_addr_i(io_addr_i), .np_hit_o(np_hit_o),
        .pref_hit_o(pref_hit_o), .io_hit_o(io_hit_o), .pref_addr64_capable_o(pcap),
        .io_addr32_capable_o(io_addr32_capable));

    function automatic int slot(input logic [9:0] ix);
        foreach (IDX[i]) if (IDX[i] == ix) return i;
        return -1;
    endfunction
    // upper registers are frozen and read zero while their capability is clear
    function automatic logic gated(input int s);
        return ((s == 6 || s == 7) && !mr[4][0]) || ((s == 8 || s == 9) && !mr[0][0]);
    endfunction
    function automatic logic [31:0] exp_rd(input int s);
        logic [31:0] v;
        if (s < 0 || gated(s)) return 32'h0;
        v = mr[s];
        if (s == 1) v[0] = mr[0][0];
        if (s == 5) v[0] = mr[4][0];
        return v;
    endfunction
    function automatic logic [63:0] win(input int w, input logic hi);
        logic [31:0] pu, iu;
        pu = mr[4][0] ? mr[hi ? 7 : 6] : 32'h0;
        iu = mr[0][0] ? mr[hi ? 9 : 8] : 32'h0;
        case (w)
            0: return {32'h0, mr[hi ? 3 : 2][15:4], hi ? 20'hfffff : 20'h0};
            1: return {pu, mr[hi ? 5 : 4][15:4], hi ? 20'hfffff : 20'h0};
            default: return {32'h0, iu[15:0], mr[hi ? 1 : 0][7:4], hi ? 12'hfff : 12'h0};
        endcase
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic er);
        @(posedge clk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1;
        // no cap on the wait: a missing ready is caught by the run's timeout
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task automatic rw(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] v, m;
        logic        e;
        int          s;
        s = slot(a[11:2]);
        apb(wr, a, d, st, v, e);
        chk(e, s < 0, "error flag");
        if (!wr)
            chk(v, exp_rd(s), "read data");
        else if (s >= 0 && !gated(s)) begin
            m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & WMSK[s];
            mr[s] = (mr[s] & ~m) | (d & m);
        end
    endtask
    task automatic hit_chk(input int k);
        logic [63:0] a [3];
        for (int w = 0; w < 3; w++) begin
            case (k)
                0: a[w] = win(w, 0) - 1;
                1: a[w] = win(w, 0);
                2: a[w] = win(w, 1);
                3: a[w] = win(w, 1) + 1;
                default: a[w] = {$urandom, $urandom};
            endcase
        end
        a[0][63:32] = 0;
        a[2][63:32] = 0;
        np_addr_i <= a[0][31:0];
        pref_addr_i <= a[1];
        io_addr_i <= a[2][31:0];
        repeat (2) @(posedge clk_i);
        chk(np_hit_o, win(0, 0) <= a[0] && a[0] <= win(0, 1), "np hit");
        chk(pref_hit_o, win(1, 0) <= a[1] && a[1] <= win(1, 1), "pref hit");
        chk(io_hit_o, win(2, 0) <= a[2] && a[2] <= win(2, 1), "io hit");
        chk(pcap, mr[4][0], "pref cap");
        chk(io_addr32_capable, mr[0][0], "io cap");
    endtask
    task automatic reset_all();
        rst_i <= 1;
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        mr = RSTV;
        for (int s = 0; s < 10; s++)
            rw(0, {IDX[s], 2'b00}, $urandom, 4'hf);
        rw(0, 12'h084, 32'h0, 4'hf);
        for (int k = 0; k < 5; k++)
            hit_chk(k);
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        // the full run needs about 850 cycles; the ceiling leaves ample margin
        if (cyc == 5000) begin
            error_cnt++;
            $display("unexpected at %0t: timeout", $time);
            give_verdict();
        end
    end

    initial begin
        void'($urandom(32'h5c11ae6f));
        reset_all();
        $display("test reset values done");
        // capabilities cleared: uppers must drop writes and read zero
        rw(1, 12'h090, 32'h00001230, 4'hf);
        rw(1, 12'h070, 32'h00000050, 4'h1);
        rw(1, 12'h0a0, 32'h12345678, 4'hf);
        rw(1, 12'h0c0, 32'h0000abcd, 4'hf);
        for (int s = 0; s < 10; s++)
            rw(0, {IDX[s], 2'b00}, 32'h0, 4'hf);
        for (int k = 0; k < 5; k++)
            hit_chk(k);
        $display("test capability clear done");
        repeat (80) begin
            rw(1, {IDX[$urandom_range(9)], 2'b00}, $urandom, 4'($urandom));
            rw(0, {IDX[$urandom_range(9)], 2'b00}, 32'h0, 4'hf);
            if ($urandom_range(7) == 0)
                rw(1, 12'($urandom) & 12'hffc, $urandom, 4'hf);
            hit_chk($urandom_range(4));
        end
        $display("test random traffic done");
        reset_all();
        $display("test second reset done");
        give_verdict();
    end
endmodule // testbench
